/* File: vlc_pkg.sv */
// constants, field layouts and carriers of the vehicle link
// control/status block; assumes a 100 MHz module clock.
//
// Behaviour
// - Enables 6..4 gate tx idle, empty, under/over-run to tx request.
// - Enables 3..0 gate overrun, completion, break, full to rx request.
// - Cleared enable blocks only the request; flag events still pass.
// - Active driven, passive seen sets sticky tx fault; write 0 clears.
// - In-frame bit sets on norm bit rise; code read or good byte clears.
// - Idle bit reads 1 after more than 280 us without link activity.
// - No active edge in 80 minus cal us after SOF: short, tx reset.
// - Filtered short pulse sets sticky noise bit.
// - Activity with wake enable sets wake; status read clears both.
// - CRC off: no CRC appended or checked.
// - CRC on: append and check; mismatch flags the completion code.
// - Quad speed bit quadruples rate; received break clears it.
// - Quad change resets machine, clears resp/DMA, loads default cal.
// - Type 2 retries response each byte boundary until won, then clears.
// - Polarity bit decides which normalization value means CRC follows.
// - Writing 1 to abort resets tx, sets idle and empty; reads 0.
// - Break self-clears when sent, clears resp/quad/DMA, flags completion.
// - Response mode starts after EOD; otherwise after EOF or idle link.
// - Receive error, break or quad reset clears response mode.
// - Wake enable allows wake interrupt; cleared once wake occurs.
// - Events while enable is 0 raise no request, never pending later.
package vlc_pkg;

	localparam int CLK_PERIOD_NS = 10;
	localparam int IDLE_TIME_US  = 280;
	localparam int IDLE_CYCLES   = IDLE_TIME_US * 1000 / CLK_PERIOD_NS;
	localparam int US_CYCLES     = 1000 / CLK_PERIOD_NS;
	localparam int SHORT_BASE_US = 80;

	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_IRQ_EN  = 8'h00;
	localparam logic [7:0] ADDR_STATUS  = 8'h04;
	localparam logic [7:0] ADDR_CONTROL = 8'h08;
	localparam logic [7:0] RESET_VALUE  = 8'h00;

	// status fields
	localparam int ST_TX_FAULT = 5;
	localparam int ST_IFR      = 4;
	localparam int ST_IDLE     = 3;
	localparam int ST_SHORT    = 2;
	localparam int ST_NOISE    = 1;
	localparam int ST_WAKE     = 0;

	// control fields
	localparam int CT_CRC_OFF = 7;
	localparam int CT_QUAD    = 6;
	localparam int CT_TYPE2   = 5;
	localparam int CT_NORM_BIT_POLARITY   = 4;
	localparam int CT_ABORT   = 3;
	localparam int CT_BREAK   = 2;
	localparam int CT_TX_IFR  = 1;
	localparam int CT_WAKE_EN = 0;

	// flag events, bit order matches the enable register 6..0
	typedef struct packed {
		logic tx_idle;
		logic tx_buf_empty;
		logic tx_under_over;
		logic rx_overrun;
		logic completion;
		logic brk;
		logic rx_buf_full;
	} vlc_flags_s;

	typedef struct packed {
		logic link_activity;
		logic norm_bit;
		logic tx_drive_active;
		logic sample_passive;
		logic arb_lost;
		logic sof_sent;
		logic active_edge;
		logic noise_pulse;
		logic cc_read;
		logic good_nonifr_byte;
		logic crc_bad;
		logic break_rx;
		logic rx_error;
		logic byte_boundary;
		logic arb_won;
		logic break_done;
		logic eod;
		logic eof;
		logic long_break_sel;
	} vlc_link_s;

	typedef struct packed {
		logic crc_append;
		logic crc_check;
		logic quad_speed;
		logic crc_follows;
		logic tx_in_frame_resp;
		logic type2_retry;
		logic tx_start_ok;
		logic break_req;
		logic break_long;
		logic tx_reset;
		logic sm_reset;
		logic tx_dma_clr;
		logic cal_load;
		logic cc_form;
		logic crc_mismatch;
		logic wake_irq;
	} vlc_ctl_s;

endpackage

/* File: vlc_ctrl_status.sv */
// interrupt enable gating, global status and global control of the
// single-wire vehicle link controller.
// assumes event inputs are one-cycle pulses synchronous to REF_CLK_IN.
//
// The plain strobed port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module vlc_ctrl_status
	import vlc_pkg::*;
#(
	parameter int IDLE_LIMIT = IDLE_CYCLES,
	parameter logic [7:0] CAL_NORMAL_DEF = 8'h00,
	parameter logic [7:0] CAL_QUAD_DEF   = 8'h00
)(
	input  wire logic       REF_CLK_IN,
	input  wire logic       RESET_IN,
	input  wire logic [7:0] REG_ADDR_IN,
	input  wire logic [7:0] REG_WDATA_IN,
	input  wire logic       REG_WR_IN,
	input  wire logic       REG_RD_IN,
	output logic      [7:0] REG_RDATA_OUT,
	input  vlc_flags_s      FLAG_EVENT_IN,
	input  vlc_link_s       LINK_IN,
	input  wire logic [7:0] CAL_VALUE_IN,
	output vlc_flags_s      FLAG_SET_OUT,
	output logic            TX_IRQ_OUT,
	output logic            RX_IRQ_OUT,
	output vlc_ctl_s        CTL_OUT,
	output logic      [7:0] CAL_DEFAULT_OUT
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic [6:0]  irq_en;
	logic        tx_fault_seen;
	logic        in_frame_resp_active;
	logic        link_idle;
	logic        ground_short_seen;
	logic        noise_seen;
	logic        wake_seen;
	logic        crc_off;
	logic        quad_speed;
	logic        quad_prev;
	logic        type2_resp_mode;
	logic        norm_bit_polarity;
	logic        send_break;
	logic        tx_in_frame_resp;
	logic        wake_en;
	logic        norm_prev;
	logic [15:0] idle_cnt;
	logic [6:0]  us_div;
	logic [7:0]  us_cnt;
	logic        sof_wait;
	logic        short_hit;

	logic        wr_ctl;
	logic        wr_st;
	logic        rd_st;
	logic        abort_wr;
	logic        quad_chg;
	logic        wake_hit;
	logic [7:0]  short_limit;
	vlc_flags_s  next_flags;

	assign wr_ctl   = REG_WR_IN && (REG_ADDR_IN == ADDR_CONTROL);
	assign wr_st    = REG_WR_IN && (REG_ADDR_IN == ADDR_STATUS);
	assign rd_st    = REG_RD_IN && (REG_ADDR_IN == ADDR_STATUS);
	assign abort_wr = wr_ctl && REG_WDATA_IN[CT_ABORT];
	assign quad_chg = quad_speed != quad_prev;
	assign wake_hit = wake_en && LINK_IN.link_activity;

	// trip time, never below one microsecond
	function automatic logic [7:0] trip_us(input logic [7:0] cal);
		if (cal >= 8'(SHORT_BASE_US))
			trip_us = 8'h01;
		else
			trip_us = 8'(SHORT_BASE_US) - cal;
	endfunction
	assign short_limit = trip_us(CAL_VALUE_IN);

	// ------------------------------------------------------------
	// interrupt enables and flag events
	// ------------------------------------------------------------
	always_ff @(posedge REF_CLK_IN)
	begin
		if (RESET_IN)
			irq_en <= 7'h00;
		else if (REG_WR_IN && REG_ADDR_IN == ADDR_IRQ_EN)
			irq_en <= REG_WDATA_IN[6:0];
	end

	always_comb
	begin
		next_flags = FLAG_EVENT_IN;
		if (abort_wr || short_hit)
		begin
			next_flags.tx_idle      = 1'b1;
			next_flags.tx_buf_empty = 1'b1;
		end
		if (send_break && LINK_IN.break_done)
		begin
			next_flags.completion = 1'b1;
			next_flags.brk        = 1'b1;
		end
	end

	always_ff @(posedge REF_CLK_IN)
	begin
		if (RESET_IN)
		begin
			FLAG_SET_OUT <= '0;
			TX_IRQ_OUT   <= 1'b0;
			RX_IRQ_OUT   <= 1'b0;
		end
		else
		begin
			FLAG_SET_OUT <= next_flags;
			TX_IRQ_OUT <= |(next_flags[6:4] & irq_en[6:4]);
			RX_IRQ_OUT <= |(next_flags[3:0] & irq_en[3:0]);
		end
	end

	// ------------------------------------------------------------
	// status bits
	// ------------------------------------------------------------
	// sticky fault, set wins
	always_ff @(posedge REF_CLK_IN)
	begin
		if (RESET_IN)
			tx_fault_seen <= 1'b0;
		else if (LINK_IN.tx_drive_active && LINK_IN.sample_passive
			&& !LINK_IN.arb_lost)
			tx_fault_seen <= 1'b1;
		else if (wr_st && !REG_WDATA_IN[ST_TX_FAULT])
			tx_fault_seen <= 1'b0;
	end

	always_ff @(posedge REF_CLK_IN)
	begin
		if (RESET_IN)
		begin
			norm_prev            <= 1'b0;
			in_frame_resp_active <= 1'b0;
		end
		else
		begin
			norm_prev <= LINK_IN.norm_bit;
			if (LINK_IN.norm_bit && !norm_prev)
				in_frame_resp_active <= 1'b1;
			else if (LINK_IN.cc_read || LINK_IN.good_nonifr_byte)
				in_frame_resp_active <= 1'b0;
		end
	end

	always_ff @(posedge REF_CLK_IN)
	begin
		if (RESET_IN)
		begin
			idle_cnt  <= 16'h0000;
			link_idle <= 1'b0;
		end
		else if (LINK_IN.link_activity)
		begin
			idle_cnt  <= 16'h0000;
			link_idle <= 1'b0;
		end
		else if (idle_cnt < 16'(IDLE_LIMIT))
			idle_cnt <= idle_cnt + 16'h0001;
		else
			link_idle <= 1'b1;
	end

	always_ff @(posedge REF_CLK_IN)
	begin
		if (RESET_IN)
		begin
			sof_wait  <= 1'b0;
			us_div    <= 7'h00;
			us_cnt    <= 8'h00;
			short_hit <= 1'b0;
		end
		else
		begin
			short_hit <= 1'b0;
			if (LINK_IN.sof_sent)
			begin
				sof_wait <= 1'b1;
				us_div   <= 7'h00;
				us_cnt   <= 8'h00;
			end
			else if (LINK_IN.active_edge || abort_wr)
				sof_wait <= 1'b0;
			else if (sof_wait)
			begin
				if (us_div == 7'(US_CYCLES - 1))
				begin
					us_div <= 7'h00;
					us_cnt <= us_cnt + 8'h01;
					if (us_cnt + 8'h01 >= short_limit)
					begin
						sof_wait  <= 1'b0;
						short_hit <= 1'b1;
					end
				end
				else
					us_div <= us_div + 7'h01;
			end
		end
	end

	always_ff @(posedge REF_CLK_IN)
	begin
		if (RESET_IN)
			ground_short_seen <= 1'b0;
		else if (short_hit)
			ground_short_seen <= 1'b1;
	end

	always_ff @(posedge REF_CLK_IN)
	begin
		if (RESET_IN)
			noise_seen <= 1'b0;
		else if (LINK_IN.noise_pulse)
			noise_seen <= 1'b1;
	end

	// wake status, read clears unless a new hit
	always_ff @(posedge REF_CLK_IN)
	begin
		if (RESET_IN)
			wake_seen <= 1'b0;
		else if (wake_hit)
			wake_seen <= 1'b1;
		else if (rd_st)
			wake_seen <= 1'b0;
	end

	// ------------------------------------------------------------
	// control bits
	// ------------------------------------------------------------
	always_ff @(posedge REF_CLK_IN)
	begin
		if (RESET_IN)
		begin
			crc_off           <= 1'b0;
			norm_bit_polarity <= 1'b0;
		end
		else if (wr_ctl)
		begin
			crc_off           <= REG_WDATA_IN[CT_CRC_OFF];
			norm_bit_polarity <= REG_WDATA_IN[CT_NORM_BIT_POLARITY];
		end
	end

	// quad speed, cleared by received or sent break
	always_ff @(posedge REF_CLK_IN)
	begin
		if (RESET_IN)
		begin
			quad_speed <= 1'b0;
			quad_prev  <= 1'b0;
		end
		else
		begin
			quad_prev <= quad_speed;
			if (LINK_IN.break_rx || (send_break && LINK_IN.break_done))
				quad_speed <= 1'b0;
			else if (wr_ctl)
				quad_speed <= REG_WDATA_IN[CT_QUAD];
		end
	end

	// type 2 clears once arbitration won
	always_ff @(posedge REF_CLK_IN)
	begin
		if (RESET_IN)
			type2_resp_mode <= 1'b0;
		else if (type2_resp_mode && LINK_IN.arb_won)
			type2_resp_mode <= 1'b0;
		else if (wr_ctl)
			type2_resp_mode <= REG_WDATA_IN[CT_TYPE2];
	end

	always_ff @(posedge REF_CLK_IN)
	begin
		if (RESET_IN)
			send_break <= 1'b0;
		else if (send_break && LINK_IN.break_done)
			send_break <= 1'b0;
		else if (wr_ctl && REG_WDATA_IN[CT_BREAK])
			send_break <= 1'b1;
	end

	always_ff @(posedge REF_CLK_IN)
	begin
		if (RESET_IN)
			tx_in_frame_resp <= 1'b0;
		else if (LINK_IN.rx_error || LINK_IN.break_rx || quad_chg
			|| (send_break && LINK_IN.break_done))
			tx_in_frame_resp <= 1'b0;
		else if (wr_ctl)
			tx_in_frame_resp <= REG_WDATA_IN[CT_TX_IFR];
	end

	always_ff @(posedge REF_CLK_IN)
	begin
		if (RESET_IN)
			wake_en <= 1'b0;
		else if (wake_hit || rd_st)
			wake_en <= 1'b0;
		else if (wr_ctl)
			wake_en <= REG_WDATA_IN[CT_WAKE_EN];
	end

	// ------------------------------------------------------------
	// outputs towards transmitter and receiver
	// ------------------------------------------------------------
	always_ff @(posedge REF_CLK_IN)
	begin
		if (RESET_IN)
		begin
			CTL_OUT         <= '0;
			CAL_DEFAULT_OUT <= CAL_NORMAL_DEF;
		end
		else
		begin
			CTL_OUT.crc_append   <= !crc_off;
			CTL_OUT.crc_check    <= !crc_off;
			CTL_OUT.crc_mismatch <= !crc_off && LINK_IN.crc_bad;
			CTL_OUT.quad_speed   <= quad_speed;
			CTL_OUT.crc_follows <= LINK_IN.norm_bit ^ norm_bit_polarity;
			CTL_OUT.tx_in_frame_resp <= tx_in_frame_resp;
			CTL_OUT.type2_retry <= type2_resp_mode
				&& LINK_IN.byte_boundary && !LINK_IN.arb_won;
			CTL_OUT.tx_start_ok <= tx_in_frame_resp ? LINK_IN.eod
				: (LINK_IN.eof || link_idle);
			CTL_OUT.break_req  <= send_break && !LINK_IN.break_done;
			CTL_OUT.break_long <= LINK_IN.long_break_sel;
			CTL_OUT.tx_reset <= abort_wr || short_hit;
			CTL_OUT.sm_reset   <= quad_chg;
			CTL_OUT.cal_load   <= quad_chg;
			CTL_OUT.tx_dma_clr <= quad_chg
				|| (send_break && LINK_IN.break_done);
			CTL_OUT.cc_form  <= send_break && LINK_IN.break_done;
			CTL_OUT.wake_irq <= wake_hit;
			if (quad_chg)
				CAL_DEFAULT_OUT <= quad_speed ? CAL_QUAD_DEF
					: CAL_NORMAL_DEF;
		end
	end

	// ------------------------------------------------------------
	// register read, data one cycle after the strobe
	// ------------------------------------------------------------
	always_ff @(posedge REF_CLK_IN)
	begin
		if (RESET_IN)
			REG_RDATA_OUT <= RESET_VALUE;
		else if (!REG_RD_IN)
			REG_RDATA_OUT <= RESET_VALUE;
		else
			case (REG_ADDR_IN)
				ADDR_IRQ_EN:  REG_RDATA_OUT <= {1'b0, irq_en};
				ADDR_STATUS:  REG_RDATA_OUT <= {2'b00, tx_fault_seen,
					in_frame_resp_active, link_idle,
					ground_short_seen, noise_seen, wake_seen};
				ADDR_CONTROL: REG_RDATA_OUT <= {crc_off, quad_speed,
					type2_resp_mode, norm_bit_polarity, 1'b0,
					send_break, tx_in_frame_resp, wake_en};
				default:      REG_RDATA_OUT <= RESET_VALUE;
			endcase
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	sequence s_break_end;
		send_break && LINK_IN.break_done;
	endsequence

	property p_tx_irq;
		@(posedge REF_CLK_IN) disable iff (RESET_IN)
		(FLAG_EVENT_IN.tx_idle && irq_en[6]) |=> TX_IRQ_OUT;
	endproperty
	a_tx_irq: assert property (p_tx_irq)
		else $error("tx request missing");

	property p_rx_gate;
		@(posedge REF_CLK_IN) disable iff (RESET_IN)
		(irq_en[3:0] == 4'h0) |=> !RX_IRQ_OUT;
	endproperty
	a_rx_gate: assert property (p_rx_gate)
		else $error("rx request while disabled");

	property p_flag_pass;
		@(posedge REF_CLK_IN) disable iff (RESET_IN)
		FLAG_EVENT_IN.rx_buf_full |=> FLAG_SET_OUT.rx_buf_full;
	endproperty
	a_flag_pass: assert property (p_flag_pass)
		else $error("flag event dropped");

	property p_fault;
		@(posedge REF_CLK_IN) disable iff (RESET_IN)
		(LINK_IN.tx_drive_active && LINK_IN.sample_passive
			&& !LINK_IN.arb_lost) |=> tx_fault_seen;
	endproperty
	a_fault: assert property (p_fault)
		else $error("tx fault not recorded");

	property p_wake_read;
		@(posedge REF_CLK_IN) disable iff (RESET_IN)
		(rd_st && !wake_hit) |=> (!wake_seen && !wake_en);
	endproperty
	a_wake_read: assert property (p_wake_read)
		else $error("wake not cleared by read");

	property p_break_end;
		@(posedge REF_CLK_IN) disable iff (RESET_IN)
		s_break_end |=> (!send_break && !quad_speed
			&& !tx_in_frame_resp && FLAG_SET_OUT.brk
			&& FLAG_SET_OUT.completion && CTL_OUT.cc_form);
	endproperty
	a_break_end: assert property (p_break_end)
		else $error("break end not handled");

	property p_quad_chg;
		@(posedge REF_CLK_IN) disable iff (RESET_IN)
		$changed(quad_speed) |=> (CTL_OUT.sm_reset && CTL_OUT.cal_load
			&& CTL_OUT.tx_dma_clr && !tx_in_frame_resp);
	endproperty
	a_quad_chg: assert property (p_quad_chg)
		else $error("mode change effects missing");

	property p_abort;
		@(posedge REF_CLK_IN) disable iff (RESET_IN)
		abort_wr |=> (CTL_OUT.tx_reset && FLAG_SET_OUT.tx_idle
			&& FLAG_SET_OUT.tx_buf_empty);
	endproperty
	a_abort: assert property (p_abort)
		else $error("abort effects missing");

	property p_idle;
		@(posedge REF_CLK_IN) disable iff (RESET_IN)
		LINK_IN.link_activity |=> !link_idle;
	endproperty
	a_idle: assert property (p_idle)
		else $error("idle while link active");

endmodule // vlc_ctrl_status

/* File: vlc_link_node.sv */
// far-side node model: raises link events for the controller
// assumes callers run in the REF_CLK_IN domain
`timescale 1ns/1ps
module vlc_link_node
	import vlc_pkg::*;
(
	input  wire logic clk_in,
	output vlc_link_s link_out
);
	vlc_link_s pulse;
	logic      nb;
	logic      lb;

	initial
	begin
		pulse = '0;
		nb = 1'b0;
		lb = 1'b0;
	end

	// levels ride beside the one-cycle events
	always_comb
	begin
		link_out = pulse;
		link_out.norm_bit = nb;
		link_out.long_break_sel = lb;
	end

	// one-cycle event, raised right after an edge
	task automatic send(input vlc_link_s m);
		@(posedge clk_in);
		pulse <= m;
		@(posedge clk_in);
		pulse <= '0;
	endtask
endmodule // vlc_link_node

/* File: vlc_ctrl_status_bench.sv */
// self-checking bench of the link control/status block
// assumes vlc_pkg and vlc_link_node are compiled first
`timescale 1ns/1ps
module vlc_ctrl_status_bench;
	import vlc_pkg::*;
	localparam logic [7:0] QDEF = 8'h5A;
	localparam logic [7:0] NDEF = 8'h3C;
	logic       clk = 1'b0;
	logic       rst = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic       wr = 1'b0;
	logic       rd = 1'b0;
	logic [7:0] cal = 8'h46;
	vlc_flags_s fev = '0;
	vlc_link_s  link;
	logic [7:0] rdata;
	logic [7:0] cald;
	vlc_flags_s fset;
	vlc_ctl_s   ctl;
	logic       txi;
	logic       rxi;
	vlc_flags_s sf;
	vlc_ctl_s   sc;
	logic [1:0] si;
	int         miscompares = 0;
	int         num_checks = 0;
	int         i;
	int         j;

	always #5 clk = ~clk;

	vlc_link_node i_node (.clk_in(clk), .link_out(link));

	vlc_ctrl_status #(.IDLE_LIMIT(50), .CAL_NORMAL_DEF(NDEF),
		.CAL_QUAD_DEF(QDEF)) i_dut (
		.REF_CLK_IN(clk), .RESET_IN(rst), .REG_ADDR_IN(addr),
		.REG_WDATA_IN(wdata), .REG_WR_IN(wr), .REG_RD_IN(rd),
		.REG_RDATA_OUT(rdata), .FLAG_EVENT_IN(fev), .LINK_IN(link),
		.CAL_VALUE_IN(cal), .FLAG_SET_OUT(fset), .TX_IRQ_OUT(txi),
		.RX_IRQ_OUT(rxi), .CTL_OUT(ctl), .CAL_DEFAULT_OUT(cald));

	// --------------------------------------------------------
	// pulse catchers
	// --------------------------------------------------------
	always @(negedge clk)
	begin
		sf = sf | fset;
		sc = sc | ctl;
		si = si | {txi, rxi};
	end

	// --------------------------------------------------------
	// access tasks
	// --------------------------------------------------------
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		num_checks++;
		if (g !== e)
		begin
			miscompares++;
			$display("ERROR %0t got %h exp %h", $time, g, e);
		end
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] m,
		input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		chk(rdata & m, e);
	endtask

	task automatic flag(input logic [6:0] f);
		@(posedge clk);
		fev <= f;
		@(posedge clk);
		fev <= '0;
	endtask

	task automatic clr;
		@(posedge clk);
		sf = '0;
		sc = '0;
		si = '0;
	endtask

	task automatic end_sim;
		if (miscompares == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial
	begin
		#200000;
		miscompares++;
		end_sim;
	end

	// --------------------------------------------------------
	// tests
	// --------------------------------------------------------
	initial
	begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		repeat (60) @(posedge clk);
		rd_chk(ADDR_IRQ_EN, 8'hFF, 8'h00);
		rd_chk(ADDR_CONTROL, 8'hFF, 8'h00);
		rd_chk(ADDR_STATUS, 8'h08, 8'h08);
		i_node.send('{link_activity: 1'b1, default: 1'b0});
		rd_chk(ADDR_STATUS, 8'h08, 8'h00);
		wr_reg(8'h0C, 8'hFF);
		rd_chk(8'h0C, 8'hFF, 8'h00);
		rd_chk(ADDR_IRQ_EN, 8'hFF, 8'h00);
		wr_reg(ADDR_IRQ_EN, 8'h7F);
		rd_chk(ADDR_IRQ_EN, 8'hFF, 8'h7F);
		for (j = 0; j < 3; j++)
			for (i = 0; i < 7; i++)
			begin
				wr_reg(ADDR_IRQ_EN, j == 0 ? 8'h7F :
					(j == 1 ? 8'h7F ^ (8'h01 << i) : 8'h00));
				clr;
				flag(7'h01 << i);
				wr_reg(ADDR_IRQ_EN, 8'h7F);
				repeat (3) @(posedge clk);
				chk({1'b0, sf}, {1'b0, 7'h01 << i});
				chk({6'h00, si}, j == 0 ? {6'h00, i >= 4, i < 4} :
					8'h00);
			end
		clr;
		i_node.send('{tx_drive_active: 1'b1, sample_passive: 1'b1,
			default: 1'b0});
		rd_chk(ADDR_STATUS, 8'h20, 8'h20);
		wr_reg(ADDR_STATUS, 8'hFF);
		rd_chk(ADDR_STATUS, 8'h20, 8'h20);
		wr_reg(ADDR_STATUS, 8'h00);
		rd_chk(ADDR_STATUS, 8'h20, 8'h00);
		chk({6'h00, si}, 8'h00);
		@(posedge clk);
		i_node.nb <= 1'b1;
		rd_chk(ADDR_STATUS, 8'h10, 8'h10);
		chk({7'h00, ctl.crc_follows}, 8'h01);
		i_node.send('{cc_read: 1'b1, default: 1'b0});
		rd_chk(ADDR_STATUS, 8'h10, 8'h00);
		@(posedge clk);
		i_node.nb <= 1'b0;
		wr_reg(ADDR_CONTROL, 8'h10);
		rd_chk(ADDR_CONTROL, 8'hFF, 8'h10);
		chk({7'h00, ctl.crc_follows}, 8'h01);
		@(posedge clk);
		i_node.nb <= 1'b1;
		rd_chk(ADDR_STATUS, 8'h10, 8'h10);
		chk({7'h00, ctl.crc_follows}, 8'h00);
		i_node.send('{good_nonifr_byte: 1'b1, default: 1'b0});
		rd_chk(ADDR_STATUS, 8'h10, 8'h00);
		wr_reg(ADDR_CONTROL, 8'h80);
		repeat (3) @(posedge clk);
		chk({6'h00, ctl.crc_append, ctl.crc_check}, 8'h00);
		clr;
		i_node.send('{crc_bad: 1'b1, default: 1'b0});
		repeat (2) @(posedge clk);
		chk({7'h00, sc.crc_mismatch}, 8'h00);
		wr_reg(ADDR_CONTROL, 8'h00);
		repeat (3) @(posedge clk);
		chk({6'h00, ctl.crc_append, ctl.crc_check}, 8'h03);
		clr;
		i_node.send('{crc_bad: 1'b1, default: 1'b0});
		repeat (2) @(posedge clk);
		chk({7'h00, sc.crc_mismatch}, 8'h01);
		clr;
		wr_reg(ADDR_CONTROL, 8'h42);
		repeat (4) @(posedge clk);
		chk({4'h0, sc.sm_reset, sc.tx_dma_clr, sc.cal_load,
			ctl.quad_speed}, 8'h0F);
		chk(cald, QDEF);
		wr_reg(ADDR_CONTROL, 8'h02);
		rd_chk(ADDR_CONTROL, 8'hFF, 8'h00);
		chk(cald, NDEF);
		wr_reg(ADDR_CONTROL, 8'h40);
		i_node.send('{break_rx: 1'b1, default: 1'b0});
		rd_chk(ADDR_CONTROL, 8'hFF, 8'h00);
		wr_reg(ADDR_CONTROL, 8'h02);
		i_node.send('{rx_error: 1'b1, default: 1'b0});
		rd_chk(ADDR_CONTROL, 8'hFF, 8'h00);
		@(posedge clk);
		i_node.lb <= 1'b1;
		wr_reg(ADDR_CONTROL, 8'h46);
		rd_chk(ADDR_CONTROL, 8'hFF, 8'h44);
		chk({6'h00, ctl.break_req, ctl.break_long}, 8'h03);
		clr;
		i_node.send('{break_done: 1'b1, default: 1'b0});
		repeat (3) @(posedge clk);
		rd_chk(ADDR_CONTROL, 8'hFF, 8'h00);
		chk({1'b0, sf}, 8'h06);
		chk({6'h00, sc.cc_form, sc.tx_dma_clr}, 8'h03);
		clr;
		wr_reg(ADDR_CONTROL, 8'h08);
		repeat (3) @(posedge clk);
		rd_chk(ADDR_CONTROL, 8'hFF, 8'h00);
		chk({1'b0, sf} & 8'h60, 8'h60);
		chk({7'h00, sc.tx_reset}, 8'h01);
		wr_reg(ADDR_CONTROL, 8'hA2);
		clr;
		i_node.send('{byte_boundary: 1'b1, default: 1'b0});
		repeat (2) @(posedge clk);
		chk({7'h00, sc.type2_retry}, 8'h01);
		i_node.send('{arb_won: 1'b1, default: 1'b0});
		rd_chk(ADDR_CONTROL, 8'hFF, 8'h82);
		clr;
		i_node.send('{eof: 1'b1, default: 1'b0});
		repeat (2) @(posedge clk);
		chk({7'h00, sc.tx_start_ok}, 8'h00);
		i_node.send('{eod: 1'b1, default: 1'b0});
		repeat (2) @(posedge clk);
		chk({7'h00, sc.tx_start_ok}, 8'h01);
		wr_reg(ADDR_CONTROL, 8'h00);
		i_node.send('{link_activity: 1'b1, default: 1'b0});
		clr;
		repeat (2) @(posedge clk);
		chk({7'h00, sc.tx_start_ok}, 8'h00);
		i_node.send('{eof: 1'b1, default: 1'b0});
		repeat (2) @(posedge clk);
		chk({7'h00, sc.tx_start_ok}, 8'h01);
		i_node.send('{noise_pulse: 1'b1, default: 1'b0});
		rd_chk(ADDR_STATUS, 8'h02, 8'h02);
		wr_reg(ADDR_CONTROL, 8'h01);
		clr;
		i_node.send('{link_activity: 1'b1, default: 1'b0});
		rd_chk(ADDR_STATUS, 8'h01, 8'h01);
		chk({7'h00, sc.wake_irq}, 8'h01);
		rd_chk(ADDR_STATUS, 8'h01, 8'h00);
		rd_chk(ADDR_CONTROL, 8'h01, 8'h00);
		i_node.send('{link_activity: 1'b1, default: 1'b0});
		rd_chk(ADDR_STATUS, 8'h01, 8'h00);
		wr_reg(ADDR_CONTROL, 8'h01);
		rd_chk(ADDR_STATUS, 8'h01, 8'h00);
		rd_chk(ADDR_CONTROL, 8'h01, 8'h00);
		i_node.send('{sof_sent: 1'b1, default: 1'b0});
		repeat (10) @(posedge clk);
		i_node.send('{active_edge: 1'b1, default: 1'b0});
		repeat (1100) @(posedge clk);
		rd_chk(ADDR_STATUS, 8'h04, 8'h00);
		clr;
		i_node.send('{sof_sent: 1'b1, default: 1'b0});
		repeat (900) @(posedge clk);
		rd_chk(ADDR_STATUS, 8'h04, 8'h00);
		repeat (200) @(posedge clk);
		rd_chk(ADDR_STATUS, 8'h04, 8'h04);
		chk({1'b0, sf} & 8'h60, 8'h60);
		chk({7'h00, sc.tx_reset}, 8'h01);
		end_sim;
	end
endmodule // vlc_ctrl_status_bench
